// ### core/sbl_defines.vh
`ifndef SBL_DEFINES_VH
`define SBL_DEFINES_VH
`define SBL_CLK_HZ 25000000
`define SBL_MODE_BYTE 8'h86
`define SBL_CMD_RAM 8'h10
`define SBL_CMD_ERASE 8'h40
`define SBL_ACK_RXERR_BIT 3
`define SBL_ACK_INVALID_BIT 0
`define SBL_TMR_W 16
`define SBL_TMR_DIV 2
`define SBL_BAUD_MIN_TICKS 16'h0010
`define SBL_BAUD_MAX_TICKS 16'hFF00
`define SBL_ERASE_ACK_OK 8'h4F
`endif

// ### core/sbl_buf2.v
`timescale 1ns/1ps
// Two-entry buffer; refuses a word while full, even if a word leaves the same cycle.
module sbl_buf2 #(
   parameter W = 8
) (
   input wire i_clk, // System clock.
   input wire i_rst, // Asynchronous reset.
   input wire i_in_valid, // Word offered.
   output wire o_in_ready, // Room for a word.
   input wire [W-1:0] i_in_data, // Word in.
   output wire o_out_valid, // Word available.
   input wire i_out_ready, // Drain accepts.
   output wire [W-1:0] o_out_data // Oldest word.
);
   reg [W-1:0] mem_q [0:1];
   reg rd_q;
   reg wr_q;
   reg [1:0] cnt_q;
   wire push;
   wire pop;
   assign o_in_ready = (cnt_q != 2'd2);
   assign o_out_valid = (cnt_q != 2'd0);
   assign o_out_data = mem_q[rd_q];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         cnt_q <= 2'd0;
         mem_q[0] <= {W{1'b0}};
         mem_q[1] <= {W{1'b0}};
      end else begin
         if (push) begin
            mem_q[wr_q] <= i_in_data;
            wr_q <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 2'd1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 2'd1;
         end
      end
   end
endmodule // sbl_buf2

// ### core/sbl_loader.v
`timescale 1ns/1ps
`include "sbl_defines.vh"
module sbl_loader #(
   parameter TW = `SBL_TMR_W
) (
   input wire i_clk, // System clock, 25 MHz.
   input wire i_rst, // Device reset, active high.
   input wire i_boot_select_n, // Boot strap pin, low selects loader.
   input wire i_loader_serial_in, // Channel-0 receive pin.
   output reg o_loader_serial_out, // Channel-0 transmit pin.
   output reg o_loader_active, // Loader mode entered.
   output reg o_boot_rom_remap, // Boot ROM over vectors, flash relocated.
   output reg o_ram_load_req, // Pulse: start the RAM-load sequence.
   output reg o_erase_req, // Pulse: erase all flash and protection.
   input wire i_op_done, // Pulse: operation sequence finished.
   input wire i_op_ok, // Result of that operation.
   input wire [7:0] i_cksum_byte, // Received checksum to judge.
   input wire [7:0] i_cksum_sum, // Running byte sum of the image.
   input wire i_cksum_valid, // Pulse: judge checksum now.
   input wire i_pw_ok, // Password check passed.
   output reg o_execute, // Pulse: jump to the loaded image.
   output reg o_halted, // Loader stopped on bad baud.
   output reg [TW-1:0] o_bit_ticks // Programmed bit period in clocks.
);
   localparam S_IDLE = 8'h01, S_MEAS = 8'h02, S_ECHO = 8'h04, S_CMD = 8'h08;
   localparam S_OP = 8'h10, S_CK = 8'h20, S_STOP = 8'h40, S_RUN = 8'h80;
   reg [7:0] st_q;
   reg rx_s1_q, rx_s2_q, rx_d_q, boot_s1_q, boot_s2_q, strap_done_q;
   reg pre_q;
   reg [1:0] strap_cnt_q;
   reg [TW-1:0] tmr_q, tab_q, tcd_q, tad_q;
   reg [2:0] edge_q;
   reg [TW-1:0] bit_q, cnt_q;
   reg [3:0] rbit_q, tbit_q;
   reg [8:0] rsh_q;
   reg rx_busy_q, rx_done_q, rx_err_q;
   reg [7:0] cmd_q;
   reg [9:0] tsh_q;
   reg tx_busy_q;
   reg [TW-1:0] tcnt_q;
   reg push_q;
   reg [7:0] push_data_q;
   wire in_ready, q_valid;
   wire [7:0] q_data;
   wire rx_fall = rx_d_q & ~rx_s2_q;
   wire rx_edge = rx_d_q ^ rx_s2_q;
   wire [7:0] ck_calc = 8'h00 - i_cksum_sum;
   wire [TW-1:0] half_bit = {1'b0, bit_q[TW-1:1]};
   sbl_buf2 #(.W(8)) u_txbuf (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_in_valid(push_q),
      .o_in_ready(in_ready),
      .i_in_data(push_data_q),
      .o_out_valid(q_valid),
      .i_out_ready(~tx_busy_q),
      .o_out_data(q_data)
   );
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= S_IDLE;
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
         rx_d_q <= 1'b1;
         boot_s1_q <= 1'b1;
         boot_s2_q <= 1'b1;
         strap_done_q <= 1'b0;
         strap_cnt_q <= 2'd0;
         pre_q <= 1'b0;
         tmr_q <= {TW{1'b0}};
         tab_q <= {TW{1'b0}};
         tcd_q <= {TW{1'b0}};
         tad_q <= {TW{1'b0}};
         edge_q <= 3'd0;
         bit_q <= {TW{1'b1}};
         cnt_q <= {TW{1'b0}};
         rbit_q <= 4'd0;
         rsh_q <= 9'h000;
         rx_busy_q <= 1'b0;
         rx_done_q <= 1'b0;
         rx_err_q <= 1'b0;
         cmd_q <= 8'h00;
         tsh_q <= 10'h3FF;
         tbit_q <= 4'd0;
         tx_busy_q <= 1'b0;
         tcnt_q <= {TW{1'b0}};
         push_q <= 1'b0;
         push_data_q <= 8'h00;
         o_loader_serial_out <= 1'b1;
         o_loader_active <= 1'b0;
         o_boot_rom_remap <= 1'b0;
         o_ram_load_req <= 1'b0;
         o_erase_req <= 1'b0;
         o_execute <= 1'b0;
         o_halted <= 1'b0;
         o_bit_ticks <= {TW{1'b1}};
      end else begin
         rx_s1_q <= i_loader_serial_in;
         rx_s2_q <= rx_s1_q;
         rx_d_q <= rx_s2_q;
         boot_s1_q <= i_boot_select_n;
         boot_s2_q <= boot_s1_q;
         pre_q <= ~pre_q;
         o_ram_load_req <= 1'b0;
         o_erase_req <= 1'b0;
         o_execute <= 1'b0;
         rx_done_q <= 1'b0;
         if (push_q & in_ready) begin
            push_q <= 1'b0;
         end
         // Strap is sampled once after release; a later change has no effect.
         // The synchroniser still holds its reset value for two edges, so wait it out.
         if (!strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 2'd1;
            if (strap_cnt_q == 2'd2) begin
               strap_done_q <= 1'b1;
               o_loader_active <= ~boot_s2_q;
               o_boot_rom_remap <= ~boot_s2_q;
            end
         end
         // Transmitter, 8N1, LSB first, fed from the buffer.
         if (!tx_busy_q) begin
            o_loader_serial_out <= 1'b1;
            if (q_valid) begin
               tsh_q <= {1'b1, q_data, 1'b0};
               tx_busy_q <= 1'b1;
               tbit_q <= 4'd0;
               tcnt_q <= {TW{1'b0}};
            end
         end else begin
            o_loader_serial_out <= tsh_q[0];
            if (tcnt_q >= bit_q - 1'b1) begin
               tcnt_q <= {TW{1'b0}};
               tsh_q <= {1'b1, tsh_q[9:1]};
               tbit_q <= tbit_q + 4'd1;
               if (tbit_q == 4'd9) begin
                  tx_busy_q <= 1'b0;
               end
            end else begin
               tcnt_q <= tcnt_q + 1'b1;
            end
         end
         // Receiver: ignores the line while replying (half duplex).
         if (st_q[3] | st_q[5]) begin
            if (!rx_busy_q) begin
               if (rx_fall && !tx_busy_q && !q_valid) begin
                  rx_busy_q <= 1'b1;
                  cnt_q <= half_bit;
                  rbit_q <= 4'd0;
               end
            end else if (cnt_q == {TW{1'b0}}) begin
               cnt_q <= bit_q - 1'b1;
               rsh_q <= {rx_s2_q, rsh_q[8:1]};
               rbit_q <= rbit_q + 4'd1;
               if (rbit_q == 4'd9) begin
                  rx_busy_q <= 1'b0;
                  rx_done_q <= 1'b1;
                  // The start sample still sits in bit 0 until this last shift.
                  rx_err_q <= ~rx_s2_q | rsh_q[0];
               end
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
         end
         case (st_q)
            S_IDLE: begin
               if (strap_done_q && o_loader_active && rx_fall) begin
                  st_q <= S_MEAS;
                  tmr_q <= {TW{1'b0}};
                  edge_q <= 3'd0;
               end
            end
            S_MEAS: begin
               // 0x86 line: start+0 low, 1-2 high, 3-6 low, 7 high, stop.
               if (pre_q && tmr_q != {TW{1'b1}}) begin
                  tmr_q <= tmr_q + 1'b1;
               end
               if (rx_edge) begin
                  edge_q <= edge_q + 3'd1;
                  if (edge_q == 3'd0) tab_q <= tmr_q;
                  if (edge_q == 3'd1) tcd_q <= tmr_q;
                  if (edge_q == 3'd2) begin
                     tad_q <= tmr_q;
                     st_q <= S_ECHO;
                  end
               end
            end
            S_ECHO: begin
               // Second interval holds two high bits against the first's two low bits.
               if (tab_q > (tcd_q - tab_q) ||
                   tad_q < `SBL_BAUD_MIN_TICKS || tad_q > `SBL_BAUD_MAX_TICKS) begin
                  st_q <= S_STOP;
                  o_halted <= 1'b1;
               end else begin
                  // Eight bit times span the check interval; two clocks per tick.
                  bit_q <= {2'b00, tad_q[TW-1:2]};
                  o_bit_ticks <= {2'b00, tad_q[TW-1:2]};
                  push_q <= 1'b1;
                  push_data_q <= `SBL_MODE_BYTE;
                  st_q <= S_CMD;
               end
            end
            S_CMD: begin
               if (rx_done_q) begin
                  // After the last shift the stop bit is bit 8 and the data bits 7..0.
                  cmd_q <= rsh_q[7:0];
                  push_q <= 1'b1;
                  if (rx_err_q) begin
                     push_data_q <= {rsh_q[7:4], 4'h8};
                  end else if (rsh_q[7:0] == `SBL_CMD_RAM ||
                               rsh_q[7:0] == `SBL_CMD_ERASE) begin
                     push_data_q <= rsh_q[7:0];
                     st_q <= S_OP;
                     o_ram_load_req <= (rsh_q[7:0] == `SBL_CMD_RAM);
                     o_erase_req <= (rsh_q[7:0] == `SBL_CMD_ERASE);
                  end else begin
                     push_data_q <= {rsh_q[7:4], 4'h1};
                  end
               end
            end
            S_OP: begin
               if (i_cksum_valid) begin
                  st_q <= S_CK;
               end else if (i_op_done) begin
                  push_q <= (cmd_q == `SBL_CMD_ERASE);
                  push_data_q <= `SBL_ERASE_ACK_OK;
                  st_q <= S_CMD;
               end
            end
            S_CK: begin
               push_q <= 1'b1;
               if (rx_err_q) begin
                  push_data_q <= {cmd_q[7:4], 4'h8};
                  st_q <= S_CMD;
               end else if (i_cksum_byte != ck_calc || !i_pw_ok) begin
                  push_data_q <= {cmd_q[7:4], 4'h1};
                  st_q <= S_CMD;
               end else begin
                  push_data_q <= {cmd_q[7:4], 4'h0};
                  st_q <= (cmd_q == `SBL_CMD_RAM && i_op_ok) ? S_RUN : S_CMD;
               end
            end
            S_RUN: begin
               if (!q_valid && !tx_busy_q && !push_q) begin
                  o_execute <= 1'b1;
                  o_boot_rom_remap <= 1'b0;
                  st_q <= S_STOP;
               end
            end
            S_STOP: begin
               st_q <= S_STOP;
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule // sbl_loader

// ### sim/sbl_loader_props.sv
`timescale 1ns/1ps
module sbl_loader_props #(
   parameter TW = 16
) (
   input wire i_clk, // Clock.
   input wire i_rst, // Reset.
   input wire o_loader_serial_out, // Transmit pin.
   input wire o_loader_active, // Loader mode.
   input wire o_boot_rom_remap, // Remap.
   input wire o_ram_load_req, // Load pulse.
   input wire o_erase_req, // Erase pulse.
   input wire o_execute, // Run pulse.
   input wire o_halted, // Stopped.
   input wire [TW-1:0] o_bit_ticks // Bit period.
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   sequence s_start_bit;
      $fell(o_loader_serial_out);
   endsequence
   sequence s_start_held;
      !o_loader_serial_out [*3];
   endsequence
   ram_pulse_a: assert property (o_ram_load_req |=> !o_ram_load_req)
      else $error("load request longer than one cycle");
   erase_pulse_a: assert property (o_erase_req |=> !o_erase_req)
      else $error("erase request longer than one cycle");
   one_request_a: assert property (!(o_ram_load_req && o_erase_req))
      else $error("load and erase requested together");
   halt_silent_a: assert property (o_halted |-> o_loader_serial_out)
      else $error("transmit while halted");
   halt_sticky_a: assert property (o_halted |=> o_halted)
      else $error("halt released without reset");
   remap_active_a: assert property (o_boot_rom_remap |-> o_loader_active)
      else $error("remap outside loader mode");
   exec_leaves_a: assert property (o_execute |=> !o_execute && !o_boot_rom_remap)
      else $error("remap kept after execute");
   idle_quiet_a: assert property (!o_loader_active |-> o_loader_serial_out)
      else $error("transmit pin used outside loader mode");
   start_bit_a: assert property (s_start_bit |-> s_start_held)
      else $error("start bit too short");
   rate_first_a: assert property (s_start_bit |-> o_bit_ticks != 16'hFFFF)
      else $error("reply sent before bit rate set");
endmodule // sbl_loader_props
bind sbl_loader sbl_loader_props #(.TW(TW)) u_props (.i_clk(i_clk), .i_rst(i_rst),
   .o_loader_serial_out(o_loader_serial_out), .o_loader_active(o_loader_active),
   .o_boot_rom_remap(o_boot_rom_remap), .o_ram_load_req(o_ram_load_req),
   .o_erase_req(o_erase_req), .o_execute(o_execute), .o_halted(o_halted),
   .o_bit_ticks(o_bit_ticks));

// ### sim/sbl_host.sv
`timescale 1ns/1ps
module sbl_host (
   input wire logic i_clk, // Clock.
   input wire logic i_tx, // Device transmit pin.
   output logic o_rx // Device receive pin.
);
   // Image placement the host keeps: above the work area, even, clear of the ID area.
   localparam logic [31:0] IMAGE_BASE = 32'h2000_0400;
   localparam logic [31:0] ID_AREA_LO = 32'h3F81_FFF0;
   initial o_rx = 1'b1;
   task automatic send_byte(input logic [7:0] b, input logic stop, input int ticks);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         o_rx <= f[i];
         repeat (ticks) @(posedge i_clk);
      end
      o_rx <= 1'b1;
   endtask
   // Gives up after limit cycles; all ones then means nothing came back.
   task automatic recv_byte(input int ticks, input int limit, output logic [8:0] b);
      int n;
      n = 0;
      b = 9'h1FF;
      while (i_tx !== 1'b0 && n < limit) begin
         @(posedge i_clk);
         n++;
      end
      if (i_tx === 1'b0) begin
         repeat (ticks / 2) @(posedge i_clk);
         for (int i = 0; i < 9; i++) begin
            repeat (ticks) @(posedge i_clk);
            b[i] = i_tx;
         end
         // Wait out the stop bit; the device ignores the line until it has sent it.
         repeat (ticks) @(posedge i_clk);
      end
   endtask
endmodule // sbl_host

// ### sim/sbl_loader_bench.sv
`timescale 1ns/1ps
module sbl_loader_bench;
   localparam int BIT = 100;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic boot_n = 1'b1;
   logic op_done = 1'b0;
   logic op_ok = 1'b0;
   logic ck_valid = 1'b0;
   logic pw_ok = 1'b0;
   logic [7:0] ck_byte = 8'h00;
   logic [7:0] ck_sum = 8'h00;
   wire rx, tx, active, remap, ram_req, erase_req, execute, halted;
   wire [15:0] bit_ticks;
   int mismatches = 0;
   int cmp_count = 0;
   int cyc = 0;
   int ram_cnt, erase_cnt, exec_cnt;
   logic [8:0] r;
   logic [7:0] cmd_t [5] = '{8'h10, 8'h40, 8'h20, 8'hF0, 8'h40};
   logic stop_t [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
   logic [7:0] ack_t [5] = '{8'h10, 8'h40, 8'h21, 8'hF1, 8'h48};
   logic [3:0] req_t [5] = '{4'h4, 4'h1, 4'h0, 4'h0, 4'h0};
   logic [7:0] ckb_t [3] = '{8'h25, 8'h26, 8'h25};
   logic pw_t [3] = '{1'b1, 1'b1, 1'b0};
   logic [8:0] ck_ack_t [3] = '{9'h110, 9'h111, 9'h111};
   logic [2:0] ex_t [3] = '{3'h2, 3'h1, 3'h1};
   always #20 i_clk = ~i_clk;
   sbl_host host (.i_clk(i_clk), .i_tx(tx), .o_rx(rx));
   sbl_loader DUT (.i_clk(i_clk), .i_rst(i_rst), .i_boot_select_n(boot_n),
      .i_loader_serial_in(rx), .o_loader_serial_out(tx), .o_loader_active(active),
      .o_boot_rom_remap(remap), .o_ram_load_req(ram_req), .o_erase_req(erase_req),
      .i_op_done(op_done), .i_op_ok(op_ok), .i_cksum_byte(ck_byte), .i_cksum_sum(ck_sum),
      .i_cksum_valid(ck_valid), .i_pw_ok(pw_ok), .o_execute(execute), .o_halted(halted),
      .o_bit_ticks(bit_ticks));
   always @(posedge i_clk) begin
      cyc++;
      if (i_rst) begin
         ram_cnt = 0;
         erase_cnt = 0;
         exec_cnt = 0;
      end else begin
         ram_cnt += (ram_req === 1'b1);
         erase_cnt += (erase_req === 1'b1);
         exec_cnt += (execute === 1'b1);
      end
      if (cyc == 80000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic reset_dut(input logic strap);
      boot_n <= strap;
      i_rst <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (8) @(posedge i_clk);
   endtask
   task automatic xfer(input logic [7:0] b, input logic stop, input int ticks,
                       input logic [8:0] exp);
      fork
         host.send_byte(b, stop, ticks);
         host.recv_byte(ticks, 3000, r);
      join
      check("reply", r, exp);
   endtask
   task automatic session();
      reset_dut(1'b0);
      xfer(8'h86, 1'b1, BIT, 9'h186);
      check("active", {active, remap}, 2'h3);
      check("bit rate", 16'(bit_ticks >= 16'h005F && bit_ticks <= 16'h0069), 16'h0001);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      // Reset is applied at the first edge; its result is looked at on the second.
      repeat (2) @(posedge i_clk);
      check("reset outputs", {tx, active, remap, ram_req, erase_req, execute, halted}, 7'h40);
      check("reset ticks", bit_ticks, 16'hFFFF);
      reset_dut(1'b1);
      check("strap high", active, 1'b0);
      xfer(8'h86, 1'b1, BIT, 9'h1FF);
      $display("test strap high done");
      for (int i = 0; i < 5; i++) begin
         session();
         xfer(cmd_t[i], stop_t[i], BIT, {1'b1, ack_t[i]});
         check("requests", {ram_cnt[1:0], erase_cnt[1:0]}, req_t[i]);
         $display("test command row %0d done", i);
      end
      for (int i = 0; i < 3; i++) begin
         session();
         xfer(8'h10, 1'b1, BIT, 9'h110);
         ck_byte <= ckb_t[i];
         ck_sum <= 8'hDB;
         pw_ok <= pw_t[i];
         op_ok <= 1'b1;
         ck_valid <= 1'b1;
         @(posedge i_clk);
         ck_valid <= 1'b0;
         host.recv_byte(BIT, 3000, r);
         check("checksum ack", r, ck_ack_t[i]);
         for (int n = 0; n < 300 && exec_cnt == 0; n++) @(posedge i_clk);
         check("execute", {exec_cnt[1:0], remap}, ex_t[i]);
         $display("test checksum row %0d done", i);
      end
      session();
      xfer(8'h40, 1'b1, BIT, 9'h140);
      op_done <= 1'b1;
      @(posedge i_clk);
      op_done <= 1'b0;
      host.recv_byte(BIT, 3000, r);
      check("erase ack", r, 9'h14F);
      $display("test erase done");
      reset_dut(1'b0);
      xfer(8'h86, 1'b1, 2, 9'h1FF);
      check("halted", halted, 1'b1);
      $display("test bad baud done");
      report_and_stop();
   end
endmodule // sbl_loader_bench
